// *** srr_top.sv ***
// Soft row repair sequencer with repair store and register port
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
module srr_top
    import srr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire srr_ca_t ca_pins,
    input wire logic [2*DQ_W-1:0] dq_pins,
    input wire srr_bus_t bus,
    output logic [DW-1:0] rd_data,
    output logic repair_mode
);
    typedef struct packed {
        srr_state_t state;
        logic mode;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [ROW_W-1:0] row;
        logic [WL_W-1:0] cnt;
        logic all_low;
        logic [1:0] high_run;
        logic [NUM_BG-1:0] res;
        logic [WL_W-1:0] wl;
        logic illegal;
        srr_outcome_t outcome;
        logic mem_we;
        srr_entry_t mem_entry;
        logic rd_mem;
        logic [DW-1:0] rdata;
    } srr_top_st_t;

    srr_top_st_t st_q;
    srr_top_st_t st_d;
    srr_ca_t ca_s;
    logic [2*DQ_W-1:0] dq_s;
    srr_entry_t mem_rd;

    // Pins cross in from the controller's clock
    srr_sync #(.W($bits(srr_ca_t))) u_sync_ca (
        .clock(clock),
        .rst(rst),
        .din(ca_pins),
        .dout(ca_s)
    );

    srr_sync #(.W(2 * DQ_W)) u_sync_dq (
        .clock(clock),
        .rst(rst),
        .din(dq_pins),
        .dout(dq_s)
    );

    srr_repair_mem u_mem (
        .clock(clock),
        .rst(rst),
        .wr_en(st_q.mem_we),
        .wr_bg(st_q.bg),
        .wr_entry(st_q.mem_entry),
        .rd_en(bus.re),
        .rd_bg(bus.addr[3:2]),
        .rd_entry(mem_rd)
    );

    logic mr4_wr;
    logic quiet;
    logic dq_low;
    logic dq_high;
    logic fin_low;
    logic [1:0] run_nx;

    // Command class decode
    always_comb
    begin
        mr4_wr = (ca_s.cmd == CMD_MRS) && ({ca_s.bg[0], ca_s.ba} == MR4_SEL);
        quiet = (ca_s.cmd == CMD_DES);
        dq_low = (dq_s == '0);
        dq_high = (&dq_s);
        fin_low = st_q.all_low && dq_low;
        run_nx = dq_high ? ((st_q.high_run == HIGH_RUN_MIN) ? HIGH_RUN_MIN
                                                            : st_q.high_run + 2'h1)
                         : 2'h0;
    end

    // Register port, sequencer and data check in one next-state block
    always_comb
    begin
        st_d = st_q;
        st_d.mem_we = 1'b0;
        // Software writes
        if (bus.we && (bus.addr == OFF_CTRL))
        begin
            st_d.res = bus.wdata[CTRL_RES_LSB +: NUM_BG];
            st_d.wl = bus.wdata[CTRL_WL_LSB +: WL_W];
        end
        if (bus.we && (bus.addr == OFF_STATUS) && bus.wdata[ST_ILLEGAL_BIT])
        begin
            st_d.illegal = 1'b0;
        end
        // Software reads, one cycle later
        if (bus.re)
        begin
            st_d.rd_mem = ((bus.addr & OFF_ENTRY_MASK) == OFF_ENTRY_BASE)
                && (bus.addr[1:0] == 2'h0);
            st_d.rdata = '0;
            case (bus.addr)
                OFF_CTRL:
                begin
                    st_d.rdata[CTRL_RES_LSB +: NUM_BG] = st_q.res;
                    st_d.rdata[CTRL_WL_LSB +: WL_W] = st_q.wl;
                end
                OFF_STATUS:
                begin
                    st_d.rdata[5:0] = st_q.state;
                    st_d.rdata[ST_ILLEGAL_BIT] = st_q.illegal;
                    st_d.rdata[ST_OUT_LSB +: 2] = st_q.outcome;
                    st_d.rdata[ST_MODE_BIT] = st_q.mode;
                end
                OFF_FLAGS:
                begin
                    // Soft resource exists only while hard resource remains
                    st_d.rdata[FLAG_HARD_BIT] = |st_q.res;
                    st_d.rdata[FLAG_SOFT_BIT] = |st_q.res;
                end
                OFF_ACT_LIMIT:
                begin
                    // Unlimited since neighbour refresh is automatic
                    st_d.rdata[3:0] = MAC_CODE;
                end
                default:
                begin
                    st_d.rdata = '0;
                end
            endcase
        end
        // Mode register 4 bit 5 steers the mode from any state
        if (mr4_wr)
        begin
            st_d.mode = ca_s.addr[MR4_EN_BIT];
            st_d.state = ca_s.addr[MR4_EN_BIT] ? ST_ARMED : ST_IDLE;
        end
        else
        begin
            case (st_q.state)
                ST_IDLE:
                begin
                    st_d.state = ST_IDLE;
                end
                ST_ARMED:
                begin
                    if (ca_s.cmd == CMD_ACT)
                    begin
                        st_d.bg = ca_s.bg;
                        st_d.ba = ca_s.ba;
                        st_d.row = ca_s.addr;
                        st_d.state = ST_OPEN;
                    end
                    else if (!quiet && (ca_s.cmd != CMD_PRE))
                    begin
                        st_d.illegal = 1'b1;
                    end
                end
                ST_OPEN:
                begin
                    // Column address is ignored on the repair write
                    if ((ca_s.cmd == CMD_WR) && (ca_s.bg == st_q.bg) && (ca_s.ba == st_q.ba))
                    begin
                        st_d.cnt = st_q.wl;
                        st_d.state = ST_LATENCY;
                    end
                    else if (ca_s.cmd == CMD_PRE)
                    begin
                        st_d.state = ST_ARMED;
                    end
                    else if (!quiet)
                    begin
                        st_d.illegal = 1'b1;
                    end
                end
                ST_LATENCY:
                begin
                    // A latency of zero is treated as one clock
                    st_d.cnt = st_q.cnt - CNT_LAST;
                    if (st_q.cnt <= CNT_LAST)
                    begin
                        st_d.cnt = DATA_CLKS;
                        st_d.all_low = 1'b1;
                        st_d.high_run = 2'h0;
                        st_d.state = ST_DATA;
                    end
                    if (!quiet)
                    begin
                        st_d.illegal = 1'b1;
                    end
                end
                ST_DATA:
                begin
                    st_d.all_low = fin_low;
                    st_d.high_run = run_nx;
                    st_d.cnt = st_q.cnt - CNT_LAST;
                    if (st_q.cnt == CNT_LAST)
                    begin
                        st_d.state = ST_DONE;
                        if (fin_low && st_q.res[st_q.bg])
                        begin
                            st_d.mem_we = 1'b1;
                            st_d.mem_entry = {1'b1, st_q.ba, st_q.row};
                            st_d.outcome = OUT_REPAIRED;
                        end
                        else if (run_nx == HIGH_RUN_MIN)
                        begin
                            st_d.outcome = OUT_KEPT;
                        end
                        else
                        begin
                            // No resource or mixed pattern: nothing stored
                            st_d.outcome = OUT_SKIPPED;
                        end
                    end
                    if (!quiet)
                    begin
                        st_d.illegal = 1'b1;
                    end
                end
                ST_DONE:
                begin
                    // Row is programmed during write recovery before PRE
                    if (ca_s.cmd == CMD_PRE)
                    begin
                        st_d.state = ST_ARMED;
                    end
                    else if (!quiet)
                    begin
                        st_d.illegal = 1'b1;
                    end
                end
                default:
                begin
                    st_d.state = ST_IDLE;
                end
            endcase
        end
    end

    // State register; store contents survive mode exits
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_q <= '0;
            st_q.state <= ST_IDLE;
            st_q.res <= CTRL_RES_RST;
            st_q.wl <= CTRL_WL_RST;
            st_q.outcome <= OUT_NONE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Entry reads come from the store's own output register
    assign rd_data = st_q.rd_mem ? {mem_rd.valid, 9'h000, mem_rd.ba, 2'h0, mem_rd.row}
                                 : st_q.rdata;
    assign repair_mode = st_q.mode;
endmodule

// *** srr_pkg.sv ***
// Constants, types and register map of the soft row repair block
//
// Operation
// - MR4 bit 5 enters, clearing it leaves
// - Repairs persist until reset or overwrite
// - One repaired row per bank group, newest wins
// - Bank group without resource ignores repair
// - Repair only when all burst bits low
// - Two all-high clocks mean no repair
// - Page 2 flags report hard/soft availability
// - Page 3 bits 3:0 encode activate limit
// - Adjacent row refresh runs in background
package srr_pkg;
    localparam int DQ_W = 8;
    localparam int ROW_W = 18;
    localparam int NUM_BG = 4;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int WL_W = 6;
    // Register byte addresses
    localparam logic [AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [AW-1:0] OFF_STATUS = 8'h04;
    localparam logic [AW-1:0] OFF_FLAGS = 8'h08;
    localparam logic [AW-1:0] OFF_ACT_LIMIT = 8'h0C;
    localparam logic [AW-1:0] OFF_ENTRY_BASE = 8'h10;
    localparam logic [AW-1:0] OFF_ENTRY_MASK = 8'hF0;
    // Control fields
    localparam int CTRL_RES_LSB = 0;
    localparam int CTRL_WL_LSB = 8;
    localparam logic [NUM_BG-1:0] CTRL_RES_RST = 4'hF;
    localparam logic [WL_W-1:0] CTRL_WL_RST = 6'h0C;
    // Status fields
    localparam int ST_ILLEGAL_BIT = 8;
    localparam int ST_OUT_LSB = 10;
    localparam int ST_MODE_BIT = 12;
    // Mode register 4 select and enable bit
    localparam logic [2:0] MR4_SEL = 3'h4;
    localparam int MR4_EN_BIT = 5;
    // Availability flags and activate limit
    localparam int FLAG_HARD_BIT = 7;
    localparam int FLAG_SOFT_BIT = 6;
    localparam logic [3:0] MAC_UNLIMITED = 4'h8;
    localparam logic [3:0] MAC_CODE = MAC_UNLIMITED;
    // Data phase length and all-high run that cancels a repair
    localparam logic [WL_W-1:0] DATA_CLKS = 6'h04;
    localparam logic [1:0] HIGH_RUN_MIN = 2'h2;
    localparam logic [WL_W-1:0] CNT_LAST = 6'h01;

    typedef enum logic [2:0] {
        CMD_DES = 3'h0,
        CMD_MRS = 3'h1,
        CMD_ACT = 3'h2,
        CMD_WR = 3'h3,
        CMD_PRE = 3'h4,
        CMD_REF = 3'h5,
        CMD_OTHER = 3'h6
    } srr_cmd_t;

    typedef struct packed {
        srr_cmd_t cmd;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [ROW_W-1:0] addr;
    } srr_ca_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } srr_bus_t;

    typedef struct packed {
        logic valid;
        logic [1:0] ba;
        logic [ROW_W-1:0] row;
    } srr_entry_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ARMED = 6'h02,
        ST_OPEN = 6'h04,
        ST_LATENCY = 6'h08,
        ST_DATA = 6'h10,
        ST_DONE = 6'h20
    } srr_state_t;

    typedef enum logic [1:0] {
        OUT_NONE = 2'h0,
        OUT_REPAIRED = 2'h1,
        OUT_KEPT = 2'h2,
        OUT_SKIPPED = 2'h3
    } srr_outcome_t;
endpackage

// *** srr_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module srr_sync
    import srr_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } srr_sync_st_t;

    srr_sync_st_t st_q;
    srr_sync_st_t st_d;

    // First stage feeds only the second
    always_comb
    begin
        st_d.meta = din;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.sync;
endmodule

// *** srr_repair_mem.sv ***
// Repair address store, one entry per bank group
`timescale 1ns/100ps
module srr_repair_mem
    import srr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [1:0] wr_bg,
    input wire srr_entry_t wr_entry,
    input wire logic rd_en,
    input wire logic [1:0] rd_bg,
    output srr_entry_t rd_entry
);
    typedef struct packed {
        srr_entry_t [NUM_BG-1:0] ent;
        srr_entry_t rdata;
    } srr_mem_st_t;

    srr_mem_st_t st_q;
    srr_mem_st_t st_d;

    // Newest write to a group replaces the old address
    always_comb
    begin
        st_d = st_q;
        if (wr_en)
        begin
            st_d.ent[wr_bg] = wr_entry;
        end
        if (rd_en)
        begin
            st_d.rdata = st_q.ent[rd_bg];
        end
    end

    // Reset drops every soft repair
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rd_entry = st_q.rdata;
endmodule

// *** srr_sva.sv ***
// Port checker of the soft row repair block
`timescale 1ns/100ps
module srr_sva
    import srr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire srr_ca_t ca_pins,
    input wire logic [2*DQ_W-1:0] dq_pins,
    input wire srr_bus_t bus,
    input wire logic [DW-1:0] rd_data,
    input wire logic repair_mode
);
    logic mr4_any;
    logic mr4_set;
    logic mr4_clr;
    logic [NUM_BG-1:0] res_q;
    // Mode register 4 writes as they stand on the pins
    assign mr4_any = ca_pins.cmd == CMD_MRS && {ca_pins.bg[0], ca_pins.ba} == 3'h4;
    assign mr4_set = mr4_any && ca_pins.addr[MR4_EN_BIT];
    assign mr4_clr = mr4_any && !ca_pins.addr[MR4_EN_BIT];
    // Shadow of the resource field, since the flags derive from it
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            res_q <= CTRL_RES_RST;
        else if (bus.we && bus.addr == OFF_CTRL)
            res_q <= bus.wdata[NUM_BG-1:0];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_mode_enter: assert property (
        mr4_set ##1 (!mr4_any) [*2] |=> repair_mode) else $error("mode not entered");
    a_mode_leave: assert property (
        mr4_clr ##1 (!mr4_any) [*2] |=> !repair_mode) else $error("mode not left");
    a_rise_cause: assert property (
        $rose(repair_mode) |-> $past(mr4_set, 3)) else $error("mode rose unasked");
    a_fall_cause: assert property (
        $fell(repair_mode) |-> $past(mr4_clr, 3)) else $error("mode fell unasked");
    a_flag_bits: assert property (
        bus.re && bus.addr == OFF_FLAGS |=> rd_data[FLAG_HARD_BIT] == (|res_q)
        && rd_data[FLAG_SOFT_BIT] == (|res_q)) else $error("flags wrong");
    a_limit_code: assert property (
        bus.re && bus.addr == OFF_ACT_LIMIT |=> rd_data[3:0] == MAC_CODE)
        else $error("limit code wrong");
    a_status_mode: assert property (
        bus.re && bus.addr == OFF_STATUS |=> rd_data[ST_MODE_BIT] == $past(repair_mode))
        else $error("status mode wrong");
    a_idle_mode_off: assert property (
        bus.re && bus.addr == OFF_STATUS |=> (rd_data[5:0] == 6'h01) == !rd_data[ST_MODE_BIT])
        else $error("idle and mode disagree");
endmodule

bind srr_top srr_sva u_sva (.clock(clock), .rst(rst), .ca_pins(ca_pins), .dq_pins(dq_pins),
    .bus(bus), .rd_data(rd_data), .repair_mode(repair_mode));

// *** srr_ctrl_model.sv ***
// Memory controller model issuing the soft repair command sequence
`timescale 1ns/100ps
module srr_ctrl_model
    import srr_pkg::*;
#(
    parameter int T_MOD = 4,
    parameter int T_RCD = 3,
    parameter int T_WR = 4,
    parameter int T_EXIT = 3
)
(
    input wire logic clock,
    input wire logic start,
    input wire logic bad_ref,
    input wire logic [1:0] bg,
    input wire logic [1:0] ba,
    input wire logic [ROW_W-1:0] row,
    input wire logic [WL_W-1:0] wl,
    input wire logic [63:0] pat,
    output srr_ca_t ca_pins,
    output logic [2*DQ_W-1:0] dq_pins,
    output logic done
);
    // One command for a clock, then deselect; address keeps moving
    task automatic send(input srr_cmd_t c, input logic [1:0] g, input logic [1:0] b,
        input logic [ROW_W-1:0] a);
        ca_pins <= '{cmd: c, bg: g, ba: b, addr: a};
        @(posedge clock);
        ca_pins <= '{cmd: CMD_DES, bg: 2'h0, ba: 2'h0, addr: ~a};
    endtask
    initial
    begin
        ca_pins = '{cmd: CMD_DES, bg: 2'h0, ba: 2'h0, addr: '0};
        dq_pins = '1;
        done = 1'b0;
    end
    // Whole repair sequence; banks assumed idle, DBI and CRC off
    always
    begin
        @(posedge clock);
        if (!start)
            dq_pins <= ~dq_pins; // Released bus toggles, never a stale level
        else
        begin
            done <= 1'b0;
            dq_pins <= '1;
            send(CMD_MRS, 2'h1, 2'h0, 18'h00020);
            repeat (T_MOD - 1) @(posedge clock);
            send(CMD_ACT, bg, ba, row);
            if (bad_ref)
            begin
                @(posedge clock);
                send(CMD_REF, bg, ba, row); // Fault only on request
            end
            repeat (T_RCD - 1) @(posedge clock);
            send(CMD_WR, bg, ba, 18'h00000);
            repeat (wl) @(posedge clock);
            for (int i = 0; i < 4; i++)
            begin
                dq_pins <= pat[16*i +: 16];
                @(posedge clock);
            end
            dq_pins <= '1;
            repeat (T_WR) @(posedge clock);
            send(CMD_PRE, bg, ba, row);
            repeat (T_EXIT) @(posedge clock);
            send(CMD_MRS, 2'h1, 2'h0, 18'h00000);
            repeat (T_MOD) @(posedge clock);
            done <= 1'b1;
        end
    end
endmodule

// *** test_soft_row_repair_sequence.sv ***
// Self-checking bench of the soft row repair block
`timescale 1ns/100ps
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module test_soft_row_repair_sequence
    import srr_pkg::*;
;
    logic clock;
    logic rst;
    srr_ca_t ca_pins;
    logic [2*DQ_W-1:0] dq_pins;
    srr_bus_t bus;
    logic [DW-1:0] rd_data;
    logic repair_mode;
    logic start;
    logic bad_ref;
    logic done;
    logic [1:0] m_bg;
    logic [1:0] m_ba;
    logic [ROW_W-1:0] m_row;
    logic [63:0] m_pat;
    int err_total;
    int checks_done;
    srr_top dut (.clock(clock), .rst(rst), .ca_pins(ca_pins), .dq_pins(dq_pins), .bus(bus),
        .rd_data(rd_data), .repair_mode(repair_mode));
    srr_ctrl_model u_ctrl (.clock(clock), .start(start), .bad_ref(bad_ref), .bg(m_bg),
        .ba(m_ba), .row(m_row), .wl(6'h02), .pat(m_pat), .ca_pins(ca_pins),
        .dq_pins(dq_pins), .done(done));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clock);
        bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus <= '0;
    endtask
    // Read data appears in the cycle after the strobe and holds until the next read
    task automatic chk_rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clock);
        bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: '0};
        @(posedge clock);
        bus <= '0;
        #1 `CHK(rd_data, e)
    endtask
    task automatic run(input logic [1:0] g, input logic [1:0] b, input logic [ROW_W-1:0] r,
        input logic [63:0] p, input logic f);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        @(posedge clock);
        m_bg <= g;
        m_ba <= b;
        m_row <= r;
        m_pat <= p;
        bad_ref <= f;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        do
        begin
            @(posedge clock);
            n++;
            // Mode must show somewhere inside the sequence
            if (repair_mode === 1'b1)
                seen = 1'b1;
        end
        while (done !== 1'b1 && n < 400);
        `CHK(done, 1'b1)
        `CHK(seen, 1'b1)
        `CHK(repair_mode, 1'b0)
    endtask
    task automatic t_reset_values();
        chk_rd(OFF_CTRL, 32'h00000C0F);
        chk_rd(OFF_STATUS, 32'h00000001);
        chk_rd(OFF_FLAGS, 32'h000000C0);
        chk_rd(OFF_ACT_LIMIT, 32'h00000008);
        for (int i = 0; i < 4; i++)
            chk_rd(OFF_ENTRY_BASE + 8'(4 * i), 32'h00000000);
        chk_rd(8'h40, 32'h00000000);
        wr(OFF_FLAGS, 32'h00000000);
        chk_rd(OFF_FLAGS, 32'h000000C0);
        wr(OFF_CTRL, 32'h0000020F);
        $display("test reset_values done");
    endtask
    task automatic t_repair();
        chk_rd(OFF_FLAGS, 32'h000000C0);
        run(2'h1, 2'h2, 18'h2A5A5, '0, 1'b0);
        chk_rd(OFF_STATUS, 32'h00000401);
        chk_rd(8'h14, 32'h8022A5A5);
        run(2'h1, 2'h3, 18'h00123, '0, 1'b0);
        chk_rd(8'h14, 32'h80300123);
        chk_rd(8'h10, 32'h00000000);
        $display("test repair_overwrite done");
    endtask
    task automatic t_no_repair();
        run(2'h2, 2'h0, 18'h00001, '1, 1'b0);
        chk_rd(OFF_STATUS, 32'h00000801);
        chk_rd(8'h18, 32'h00000000);
        run(2'h2, 2'h1, 18'h00003, {4{16'h00FF}}, 1'b0);
        chk_rd(OFF_STATUS, 32'h00000C01);
        chk_rd(8'h18, 32'h00000000);
        chk_rd(8'h14, 32'h80300123);
        $display("test kept_skipped done");
    endtask
    task automatic t_no_resource();
        wr(OFF_CTRL, 32'h0000020E);
        run(2'h0, 2'h0, 18'h00005, '0, 1'b0);
        chk_rd(OFF_STATUS, 32'h00000C01);
        chk_rd(8'h10, 32'h00000000);
        wr(OFF_CTRL, 32'h00000200);
        chk_rd(OFF_FLAGS, 32'h00000000);
        wr(OFF_CTRL, 32'h0000020F);
        $display("test no_resource done");
    endtask
    task automatic t_illegal();
        run(2'h3, 2'h1, 18'h00007, '0, 1'b1);
        chk_rd(OFF_STATUS, 32'h00000501);
        chk_rd(8'h1C, 32'h80100007);
        wr(OFF_STATUS, 32'h00000100);
        chk_rd(OFF_STATUS, 32'h00000401);
        $display("test illegal_refresh done");
    endtask
    task automatic t_reset_clears();
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        chk_rd(8'h14, 32'h00000000);
        chk_rd(8'h1C, 32'h00000000);
        chk_rd(OFF_STATUS, 32'h00000001);
        chk_rd(OFF_CTRL, 32'h00000C0F);
        $display("test reset_clears done");
    endtask
    task automatic finish_test();
        $display("Checks made %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        err_total = 0;
        checks_done = 0;
        rst = 1'b1;
        bus = '0;
        start = 1'b0;
        bad_ref = 1'b0;
        m_bg = '0;
        m_ba = '0;
        m_row = '0;
        m_pat = '0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_reset_values();
        t_repair();
        t_no_repair();
        t_no_resource();
        t_illegal();
        t_reset_clears();
        finish_test();
    end
    // Whole run needs some 260 cycles; ample margin before calling it hung
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        finish_test();
    end
endmodule
